// ==== core/overtemp_pkg.sv ====
package overtemp_pkg;

    // command bytes of the register map
    localparam logic [7:0] CMD_STATUS_A   = 8'h08;
    localparam logic [7:0] CMD_STATUS_B   = 8'h09;
    localparam logic [7:0] CMD_STATUS_C   = 8'h0a;
    localparam logic [7:0] CMD_MASK_A     = 8'h0c;
    localparam logic [7:0] CMD_MASK_B     = 8'h0d;
    localparam logic [7:0] CMD_MASK_C     = 8'h0e;
    localparam logic [7:0] CMD_LIM_LOCAL  = 8'h40;
    localparam logic [7:0] CMD_LIM_R1_A   = 8'h41;
    localparam logic [7:0] CMD_LIM_R2_A   = 8'h42;
    localparam logic [7:0] CMD_LIM_R1_BC  = 8'h49;
    localparam logic [7:0] CMD_LIM_R2_BC  = 8'h4a;
    localparam logic [7:0] CMD_HYST       = 8'h5a;

    // channel bit positions, shared by status and mask registers
    localparam int BIT_LOCAL  = 0;
    localparam int BIT_REMOTE1 = 1;
    localparam int BIT_REMOTE2 = 2;
    localparam int NUM_CH     = 3;
    localparam int NUM_TIER   = 3;
    localparam int NUM_LIM    = 5;

    // field widths
    localparam int FIELD_W     = 3;
    localparam int LOCAL_LIM_W = 7;
    localparam int HYST_W      = 5;
    localparam int TEMP_W      = 8;

    // indices into the limit array
    localparam int LIM_LOCAL  = 0;
    localparam int LIM_R1_A   = 1;
    localparam int LIM_R2_A   = 2;
    localparam int LIM_R1_BC  = 3;
    localparam int LIM_R2_BC  = 4;

    // reset values
    localparam logic [FIELD_W-1:0] MASK_A_RST    = 3'h1;
    localparam logic [FIELD_W-1:0] MASK_B_RST    = 3'h0;
    localparam logic [FIELD_W-1:0] MASK_C_RST    = 3'h7;
    localparam logic [7:0]         LIM_LOCAL_RST = 8'h55;
    localparam logic [7:0]         LIM_TIER1_RST = 8'h6e;
    localparam logic [7:0]         LIM_TIER2_RST = 8'h55;
    localparam logic [HYST_W-1:0]  HYST_RST      = 5'h0a;
    localparam logic [7:0]         UNMAPPED_DATA = 8'h00;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] cmd;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic              valid;
        logic [TEMP_W-1:0] local_temp;
        logic [TEMP_W-1:0] remote1_temp;
        logic [TEMP_W-1:0] remote2_temp;
    } temps_t;

    typedef struct packed {
        logic drive;
        logic oe;
    } od_pin_t;

endpackage

// ==== core/hyst_flag.sv ====
`timescale 1ns/100ps

module hyst_flag (
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    input  wire logic                              update,
    input  wire logic [overtemp_pkg::TEMP_W-1:0]   reading,
    input  wire logic [overtemp_pkg::TEMP_W-1:0]   limit,
    input  wire logic [overtemp_pkg::HYST_W-1:0]   hyst,
    output logic                                   flag
);

    logic       flag_r;
    logic       flag_nxt;
    logic [8:0] reading_plus_hyst;

    // reading < limit - hyst written as a sum, so a hysteresis above
    // the limit never wraps and simply keeps the flag set
    assign reading_plus_hyst = {1'b0, reading} + {4'h0, hyst};

    always_comb begin
        flag_nxt = flag_r;
        if (update) begin
            if (reading >= limit) begin
                flag_nxt = 1'b1;
            end else if (reading_plus_hyst < {1'b0, limit}) begin
                flag_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign flag = flag_r;

endmodule

// ==== core/overtemp_alarm_status_mask.sv ====
`timescale 1ns/100ps

// What this block does
// R1 - third alarm asserts on any unmasked flag
// R2 - third alarm releases when flags clear
// R3 - status and mask bits 7:3 read zero
// R4 - remote two flag with hysteresis, tier two
// R5 - remote one flag with hysteresis, tier two
// R6 - local flag with hysteresis against local limit
// R7 - first mask, 0x0c reset 0x01, blocks
// R8 - second mask, 0x0d reset 0x00, blocks
// R9 - third mask, 0x0e reset 0x07, blocks
// R10 - first status flags remotes at tier one
// R11 - one shared hysteresis, 0 to 31 degrees
// R12 - alarm pins active low, released otherwise
module overtemp_alarm_status_mask (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire overtemp_pkg::reg_req_t  reg_req,
    output logic [7:0]                   reg_rdata,
    output logic                         reg_rvalid,
    input  wire overtemp_pkg::temps_t    temps,
    input  wire logic                    alarm_out_first_in,
    input  wire logic                    alarm_out_second_in,
    input  wire logic                    alarm_out_third_in,
    output overtemp_pkg::od_pin_t        alarm_out_first,
    output overtemp_pkg::od_pin_t        alarm_out_second,
    output overtemp_pkg::od_pin_t        alarm_out_third
);

    localparam int FW = overtemp_pkg::FIELD_W;
    localparam int TW = overtemp_pkg::TEMP_W;
    localparam int HW = overtemp_pkg::HYST_W;

    // configuration state
    logic [FW-1:0] mask_r   [overtemp_pkg::NUM_TIER];
    logic [FW-1:0] mask_nxt [overtemp_pkg::NUM_TIER];
    logic [TW-1:0] lim_r    [overtemp_pkg::NUM_LIM];
    logic [TW-1:0] lim_nxt  [overtemp_pkg::NUM_LIM];
    logic [HW-1:0] hyst_r;
    logic [HW-1:0] hyst_nxt;

    // read port state
    logic [7:0]    rdata_r;
    logic [7:0]    rdata_nxt;
    logic          rvalid_r;
    logic          rvalid_nxt;

    // alarm pin state
    logic [2:0]    alarm_r;
    logic [2:0]    alarm_nxt;

    // flags left after each tier's mask
    logic [FW-1:0] unmasked [overtemp_pkg::NUM_TIER];

    // one open-drain driver per tier, fanned out to the named pins
    overtemp_pkg::od_pin_t pin_drv [overtemp_pkg::NUM_TIER];

    // over-limit flags, one word per tier, bit per channel
    logic [FW-1:0] status [overtemp_pkg::NUM_TIER];
    logic [TW-1:0] reading [overtemp_pkg::NUM_CH];

    assign reading[overtemp_pkg::BIT_LOCAL]   = temps.local_temp;
    assign reading[overtemp_pkg::BIT_REMOTE1] = temps.remote1_temp;
    assign reading[overtemp_pkg::BIT_REMOTE2] = temps.remote2_temp;

    // limit that each tier and channel compares against
    function automatic int lim_index(input int tier, input int ch);
        int idx;
        idx = overtemp_pkg::LIM_LOCAL;
        if (ch == overtemp_pkg::BIT_REMOTE1) begin
            idx = (tier == 0) ? overtemp_pkg::LIM_R1_A : overtemp_pkg::LIM_R1_BC;
        end else if (ch == overtemp_pkg::BIT_REMOTE2) begin
            idx = (tier == 0) ? overtemp_pkg::LIM_R2_A : overtemp_pkg::LIM_R2_BC;
        end
        return idx;
    endfunction

    // R4 R5 R6 R10 R11 hysteresis flags
    // second and third tiers share limits but keep separate flags
    genvar gt, gc;
    generate
        for (gt = 0; gt < overtemp_pkg::NUM_TIER; gt++) begin : g_tier
            for (gc = 0; gc < overtemp_pkg::NUM_CH; gc++) begin : g_ch
                hyst_flag u_flag (
                    .clk     (clk),
                    .rst_n   (rst_n),
                    .update  (temps.valid),
                    .reading (reading[gc]),
                    .limit   (lim_r[lim_index(gt, gc)]),
                    .hyst    (hyst_r),
                    .flag    (status[gt][gc])
                );
            end
        end
    endgenerate

    // mask writes; the pin gating and the mask readback depend on them, the flags do not
    always_comb begin
        for (int i = 0; i < overtemp_pkg::NUM_TIER; i++) begin
            mask_nxt[i] = mask_r[i];
        end

        if (reg_req.wr) begin
            unique case (reg_req.cmd)
                // R7 first mask write
                overtemp_pkg::CMD_MASK_A: begin
                    mask_nxt[0] = reg_req.wdata[FW-1:0];
                end

                // R8 second mask write
                overtemp_pkg::CMD_MASK_B: begin
                    mask_nxt[1] = reg_req.wdata[FW-1:0];
                end

                // R9 third mask write
                overtemp_pkg::CMD_MASK_C: begin
                    mask_nxt[2] = reg_req.wdata[FW-1:0];
                end

                default: begin
                    // other commands leave the masks alone
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_r[0] <= overtemp_pkg::MASK_A_RST;
            mask_r[1] <= overtemp_pkg::MASK_B_RST;
            mask_r[2] <= overtemp_pkg::MASK_C_RST;
        end else begin
            for (int i = 0; i < overtemp_pkg::NUM_TIER; i++) begin
                mask_r[i] <= mask_nxt[i];
            end
        end
    end

    // limit and hysteresis writes; status registers are read-only and
    // unmapped commands fall through, so those writes are dropped
    always_comb begin
        for (int i = 0; i < overtemp_pkg::NUM_LIM; i++) begin
            lim_nxt[i] = lim_r[i];
        end

        hyst_nxt = hyst_r;
        if (reg_req.wr) begin
            unique case (reg_req.cmd)
                // local limit keeps bit 7 at zero
                overtemp_pkg::CMD_LIM_LOCAL: begin
                    lim_nxt[overtemp_pkg::LIM_LOCAL] =
                        {1'b0, reg_req.wdata[overtemp_pkg::LOCAL_LIM_W-1:0]};
                end

                overtemp_pkg::CMD_LIM_R1_A: begin
                    lim_nxt[overtemp_pkg::LIM_R1_A] = reg_req.wdata;
                end

                overtemp_pkg::CMD_LIM_R2_A: begin
                    lim_nxt[overtemp_pkg::LIM_R2_A] = reg_req.wdata;
                end

                overtemp_pkg::CMD_LIM_R1_BC: begin
                    lim_nxt[overtemp_pkg::LIM_R1_BC] = reg_req.wdata;
                end

                overtemp_pkg::CMD_LIM_R2_BC: begin
                    lim_nxt[overtemp_pkg::LIM_R2_BC] = reg_req.wdata;
                end

                // R11 shared hysteresis
                overtemp_pkg::CMD_HYST: begin
                    hyst_nxt = reg_req.wdata[HW-1:0];
                end

                default: begin
                    // read-only or unmapped: write dropped
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lim_r[overtemp_pkg::LIM_LOCAL] <= overtemp_pkg::LIM_LOCAL_RST;
            lim_r[overtemp_pkg::LIM_R1_A]  <= overtemp_pkg::LIM_TIER1_RST;
            lim_r[overtemp_pkg::LIM_R2_A]  <= overtemp_pkg::LIM_TIER1_RST;
            lim_r[overtemp_pkg::LIM_R1_BC] <= overtemp_pkg::LIM_TIER2_RST;
            lim_r[overtemp_pkg::LIM_R2_BC] <= overtemp_pkg::LIM_TIER2_RST;
            hyst_r <= overtemp_pkg::HYST_RST;
        end else begin
            for (int i = 0; i < overtemp_pkg::NUM_LIM; i++) begin
                lim_r[i] <= lim_nxt[i];
            end
            hyst_r <= hyst_nxt;
        end
    end

    // register reads, answered one cycle after the strobe
    always_comb begin
        // rdata holds the last answer, so a late look still sees it
        rdata_nxt  = rdata_r;
        rvalid_nxt = reg_req.rd;

        if (reg_req.rd) begin
            // R3 upper bits padded with zero
            unique case (reg_req.cmd)
                // R10 first status readback
                overtemp_pkg::CMD_STATUS_A: begin
                    rdata_nxt = {5'h00, status[0]};
                end

                overtemp_pkg::CMD_STATUS_B: begin
                    rdata_nxt = {5'h00, status[1]};
                end

                // R4 R5 R6 third status readback
                overtemp_pkg::CMD_STATUS_C: begin
                    rdata_nxt = {5'h00, status[2]};
                end

                overtemp_pkg::CMD_MASK_A: begin
                    rdata_nxt = {5'h00, mask_r[0]};
                end

                overtemp_pkg::CMD_MASK_B: begin
                    rdata_nxt = {5'h00, mask_r[1]};
                end

                overtemp_pkg::CMD_MASK_C: begin
                    rdata_nxt = {5'h00, mask_r[2]};
                end

                overtemp_pkg::CMD_LIM_LOCAL: begin
                    rdata_nxt = lim_r[overtemp_pkg::LIM_LOCAL];
                end

                overtemp_pkg::CMD_LIM_R1_A: begin
                    rdata_nxt = lim_r[overtemp_pkg::LIM_R1_A];
                end

                overtemp_pkg::CMD_LIM_R2_A: begin
                    rdata_nxt = lim_r[overtemp_pkg::LIM_R2_A];
                end

                overtemp_pkg::CMD_LIM_R1_BC: begin
                    rdata_nxt = lim_r[overtemp_pkg::LIM_R1_BC];
                end

                overtemp_pkg::CMD_LIM_R2_BC: begin
                    rdata_nxt = lim_r[overtemp_pkg::LIM_R2_BC];
                end

                overtemp_pkg::CMD_HYST: begin
                    rdata_nxt = {3'h0, hyst_r};
                end

                default: begin
                    rdata_nxt = overtemp_pkg::UNMAPPED_DATA;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign reg_rdata  = rdata_r;
    assign reg_rvalid = rvalid_r;

    // alarm aggregation; masks gate only the pins, flags stay visible
    always_comb begin
        for (int t = 0; t < overtemp_pkg::NUM_TIER; t++) begin
            // R7 R8 R9 set mask bit hides source
            unmasked[t]  = status[t] & ~mask_r[t];
            // R1 R2 any unmasked flag drives pin
            alarm_nxt[t] = |unmasked[t];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_r <= 3'h0;
        end else begin
            alarm_r <= alarm_nxt;
        end
    end

    genvar gp;
    generate
        for (gp = 0; gp < overtemp_pkg::NUM_TIER; gp++) begin : g_pin
            // R12 open drain, pulled low while asserted
            // drive stays low; the board pull-up makes the idle level
            assign pin_drv[gp] = '{drive: 1'b0, oe: alarm_r[gp]};
        end
    endgenerate

    assign alarm_out_first  = pin_drv[0];
    assign alarm_out_second = pin_drv[1];
    assign alarm_out_third  = pin_drv[2];

endmodule

// ==== verif/overtemp_properties.sv ====
`timescale 1ns/100ps
module overtemp_properties (
    input wire logic                   clk,
    input wire logic                   rst_n,
    input wire overtemp_pkg::reg_req_t reg_req,
    input wire logic [7:0]             reg_rdata,
    input wire logic                   reg_rvalid,
    input wire overtemp_pkg::temps_t   temps,
    input wire overtemp_pkg::od_pin_t  alarm_out_first,
    input wire overtemp_pkg::od_pin_t  alarm_out_second,
    input wire overtemp_pkg::od_pin_t  alarm_out_third
);
    logic [2:0] mask_a_r, mask_b_r, mask_c_r, mask_a_nxt, mask_b_nxt, mask_c_nxt;
    // masks are shadowed so pin checks need no hierarchy peeking
    always_comb begin
        mask_a_nxt = (reg_req.wr && reg_req.cmd == 8'h0c) ? reg_req.wdata[2:0] : mask_a_r;
        mask_b_nxt = (reg_req.wr && reg_req.cmd == 8'h0d) ? reg_req.wdata[2:0] : mask_b_r;
        mask_c_nxt = (reg_req.wr && reg_req.cmd == 8'h0e) ? reg_req.wdata[2:0] : mask_c_r;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_a_r <= 3'h1;
            mask_b_r <= 3'h0;
            mask_c_r <= 3'h7;
        end else begin
            mask_a_r <= mask_a_nxt;
            mask_b_r <= mask_b_nxt;
            mask_c_r <= mask_c_nxt;
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);
    // status read answered with flags the pins were built from
    sequence read_s(logic [7:0] c);
        reg_rvalid && $past(reg_req.cmd) == c && !$past(temps.valid);
    endsequence
    reserved_zero_a: assert property (
        reg_req.rd && reg_req.cmd inside {8'h0a, 8'h0c, 8'h0d, 8'h0e}
        |=> reg_rvalid && reg_rdata[7:3] == 5'h00) else $error("reserved bits not zero");
    read_answer_a: assert property (
        reg_rvalid == $past(reg_req.rd)) else $error("read answer out of step");
    drive_low_a: assert property (
        !alarm_out_first.drive && !alarm_out_second.drive && !alarm_out_third.drive)
        else $error("alarm pin driven high");
    first_masked_a: assert property (
        mask_a_r == 3'h7 |=> !alarm_out_first.oe) else $error("first alarm not masked");
    second_masked_a: assert property (
        mask_b_r == 3'h7 |=> !alarm_out_second.oe) else $error("second alarm not masked");
    third_masked_a: assert property (
        mask_c_r == 3'h7 |=> !alarm_out_third.oe) else $error("third alarm not masked");
    third_assert_a: assert property (
        read_s(8'h0a) ##0 (reg_rdata[2:0] & ~$past(mask_c_r)) != 3'h0 |-> alarm_out_third.oe)
        else $error("third alarm missing");
    third_release_a: assert property (
        read_s(8'h0a) ##0 reg_rdata[2:0] == 3'h0 |-> !alarm_out_third.oe)
        else $error("third alarm not released");
    first_assert_a: assert property (
        read_s(8'h08) ##0 (reg_rdata[2:0] & ~$past(mask_a_r)) != 3'h0 |-> alarm_out_first.oe)
        else $error("first alarm missing");
endmodule
bind overtemp_alarm_status_mask overtemp_properties overtemp_properties_inst (
    .clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .temps(temps), .alarm_out_first(alarm_out_first),
    .alarm_out_second(alarm_out_second), .alarm_out_third(alarm_out_third));

// ==== verif/alarm_watch.sv ====
`timescale 1ns/100ps
module alarm_watch (
    input  wire overtemp_pkg::od_pin_t first,
    input  wire overtemp_pkg::od_pin_t second,
    input  wire overtemp_pkg::od_pin_t third,
    output logic [2:0]                 level
);
    assign level = {third.oe ? third.drive : 1'b1, second.oe ? second.drive : 1'b1,
                    first.oe ? first.drive : 1'b1};
endmodule

// ==== verif/tb_overtemp_alarm_status_mask.sv ====
`timescale 1ns/100ps
module tb_overtemp_alarm_status_mask;
    logic                   clk, rst_n, reg_rvalid;
    overtemp_pkg::reg_req_t reg_req;
    overtemp_pkg::temps_t   temps;
    overtemp_pkg::od_pin_t  pa, pb, pc;
    logic [7:0]             reg_rdata;
    logic [2:0]             lvl;
    int                     miscompares = 0, num_checks = 0;

    overtemp_alarm_status_mask overtemp_alarm_status_mask_inst (.clk(clk), .rst_n(rst_n),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .temps(temps),
        .alarm_out_first_in(lvl[0]), .alarm_out_second_in(lvl[1]), .alarm_out_third_in(lvl[2]),
        .alarm_out_first(pa), .alarm_out_second(pb), .alarm_out_third(pc));
    alarm_watch alarm_watch_inst (.first(pa), .second(pb), .third(pc), .level(lvl));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        reg_req = '{rd: 1'b0, wr: 1'b1, cmd: c, wdata: d};
        @(posedge clk) #1;
        reg_req.wr = 1'b0;
        // idle edge: the next call never re-raises a strobe in this step
        @(posedge clk) #1;
    endtask
    task automatic rd(input logic [7:0] c, input logic [7:0] exp);
        reg_req.cmd = c;
        reg_req.rd = 1'b1;
        @(posedge clk) #1;
        reg_req.rd = 1'b0;
        chk("rvalid", 8'h01, {7'h00, reg_rvalid});
        chk("rdata", exp, reg_rdata);
        @(posedge clk) #1;
    endtask
    task automatic smp(input logic [7:0] l, input logic [7:0] r1, input logic [7:0] r2);
        temps = '{valid: 1'b1, local_temp: l, remote1_temp: r1, remote2_temp: r2};
        @(posedge clk) #1;
        temps.valid = 1'b0;
        @(posedge clk) #1;
    endtask
    task automatic ch(input int i, input logic [7:0] v);
        smp(i == 0 ? v : 8'h00, i == 1 ? v : 8'h00, i == 2 ? v : 8'h00);
    endtask
    // pins settle one cycle after flags or masks change
    task automatic pins(input logic [2:0] exp);
        repeat (2) @(posedge clk);
        #1;
        chk("pins", {5'h00, exp}, {5'h00, lvl});
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #20000;
        miscompares++;
        report_and_stop;
    end
    initial begin
        rst_n = 1'b0;
        reg_req = '0;
        temps = '0;
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        rd(8'h0c, 8'h01);
        rd(8'h0d, 8'h00);
        rd(8'h0e, 8'h07);
        rd(8'h0a, 8'h00);
        chk("idle pins", 8'h07, {5'h00, lvl});
        wr(8'h0d, 8'hfa);
        rd(8'h0d, 8'h02);
        wr(8'h0a, 8'hff);
        rd(8'h0a, 8'h00);
        rd(8'h33, overtemp_pkg::UNMAPPED_DATA);
        $display("test registers done");
        for (int i = 0; i < 3; i++) begin
            ch(i, 8'h55);
            rd(8'h0a, 8'h01 << i);
            ch(i, 8'h4b);
            rd(8'h0a, 8'h01 << i);
            ch(i, 8'h4a);
            rd(8'h0a, 8'h00);
        end
        smp(8'h00, 8'h6d, 8'h00);
        rd(8'h08, 8'h00);
        smp(8'h00, 8'h6e, 8'h00);
        rd(8'h08, 8'h02);
        wr(8'h5a, 8'hff);
        rd(8'h5a, 8'h1f);
        wr(8'h5a, 8'h00);
        smp(8'h00, 8'h6d, 8'h00);
        rd(8'h08, 8'h00);
        rd(8'h0a, 8'h02);
        $display("test flags done");
        smp(8'h70, 8'h70, 8'h70);
        for (int r = 0; r < 3; r++)
            wr(8'(8'h0c + r), 8'h07);
        pins(3'h7);
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < 3; i++) begin
                wr(8'(8'h0c + r), 8'h07 ^ (8'h01 << i));
                pins(3'h7 ^ (3'h1 << r));
                rd(8'(8'h08 + r), 8'h07);
                wr(8'(8'h0c + r), 8'h07);
            end
        end
        for (int r = 0; r < 3; r++)
            wr(8'(8'h0c + r), 8'h00);
        pins(3'h0);
        smp(8'h00, 8'h00, 8'h00);
        pins(3'h7);
        rd(8'h0a, 8'h00);
        $display("test pins done");
        report_and_stop;
    end
endmodule
